/* hdl/elc_ctrl.sv */
// exception and low-power controller: arbitration, break, wait and stop
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/100ps
module elc_ctrl
   import elc_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [NUM_SOURCES-1:0] src_request,
   input wire logic [NUM_SOURCES-1:0] src_enable,
   input wire logic break_request,
   input wire logic reset_request,
   input wire elc_cpu_s cpu,
   input wire logic [15:0] cpu_pc,
   output logic mask_bit,
   output logic take_exception,
   output logic [15:0] vector_addr,
   output logic [15:0] stacked_pc,
   output logic push_regs,
   output logic pop_regs,
   output logic push_index_high,
   output logic discard_prefetch,
   output logic cpu_clock_en,
   output logic periph_clock_en,
   output logic osc_clock_en,
   output logic in_break,
   output logic flag_clear_allow
);
   elc_state_e state;
   logic [15:0] next_vector;
   elc_source_e next_src;
   logic [12:0] recover_count;
   logic [7:0] break_status;
   logic [7:0] flag_ctrl;
   logic [7:0] config_one;
   logic [NUM_SOURCES-1:0] live;
   logic any_live;
   logic wake;
   logic apb_write;
   logic apb_read;
   logic [7:0] status_one;
   logic [7:0] status_two;
   logic [7:0] status_three;
   logic [12:0] recover_limit;

   // per-source gating: mask bit and own enable
   genvar g;
   generate
      for (g = 0; g < NUM_SOURCES; g++) begin : g_gate
         assign live[g] = src_request[g] & src_enable[g] & ~mask_bit;
      end
   endgenerate
   assign any_live = |live;
   assign wake = any_live | break_request | reset_request;

   // fixed priority: break and trap first, then index 0 highest
   always_comb begin
      next_src = ELC_SRC_NONE;
      next_vector = VEC_RESET;
      if (break_request | cpu.trap_instr) begin
         next_src = ELC_SRC_TRAP;
         next_vector = VEC_TRAP;
      end else if (live[0]) begin
         next_src = ELC_SRC_EXT;
         next_vector = VEC_EXT_PIN;
      end else if (live[1]) begin
         next_src = ELC_SRC_CH0;
         next_vector = VEC_CH0;
      end else if (live[2]) begin
         next_src = ELC_SRC_CH1;
         next_vector = VEC_CH1;
      end else if (live[3]) begin
         next_src = ELC_SRC_OVF;
         next_vector = VEC_OVF;
      end else if (live[4]) begin
         next_src = ELC_SRC_KEY;
         next_vector = VEC_KEYBOARD;
      end else if (live[5]) begin
         next_src = ELC_SRC_ADC;
         next_vector = VEC_ADC;
      end
   end

   assign recover_limit = config_one[BIT_SHORT_RECOVERY] ? RECOVERY_SHORT : RECOVERY_LONG;

   // exception and low-power sequencer
   always_ff @(posedge mclk) begin
      if (reset) begin
         state <= ELC_RUN;
         mask_bit <= 1'b1;
         take_exception <= 1'b0;
         vector_addr <= VEC_RESET;
         stacked_pc <= 16'h0000;
         push_regs <= 1'b0;
         pop_regs <= 1'b0;
         discard_prefetch <= 1'b0;
         cpu_clock_en <= 1'b1;
         periph_clock_en <= 1'b1;
         osc_clock_en <= 1'b1;
         recover_count <= 13'h0000;
      end else if (clk_en) begin
         take_exception <= 1'b0;
         pop_regs <= 1'b0;
         discard_prefetch <= 1'b0;
         if (reset_request) begin
            // resets override everything and never arbitrate
            state <= ELC_RUN;
            mask_bit <= 1'b1;
            take_exception <= 1'b1;
            vector_addr <= VEC_RESET;
            push_regs <= 1'b0;
            cpu_clock_en <= 1'b1;
            periph_clock_en <= 1'b1;
            osc_clock_en <= 1'b1;
            recover_count <= 13'h0000;
         end else begin
            case (state)
               ELC_RUN: begin
                  if (cpu.rti_instr) begin
                     pop_regs <= 1'b1;
                     mask_bit <= 1'b0;
                     if (|(src_request & src_enable)) begin
                        discard_prefetch <= 1'b1;
                     end
                  end
                  if (cpu.wait_instr | cpu.stop_instr) begin
                     mask_bit <= 1'b0;
                     cpu_clock_en <= 1'b0;
                     state <= cpu.stop_instr ? ELC_STOP : ELC_WAIT;
                     if (cpu.stop_instr) begin
                        periph_clock_en <= 1'b0;
                        osc_clock_en <= 1'b0;
                        recover_count <= 13'h0000;
                     end
                  // the cycle after a return re-arbitrates with the restored mask
                  end else if ((cpu.instr_done | discard_prefetch)
                               && next_src != ELC_SRC_NONE) begin
                     take_exception <= 1'b1;
                     vector_addr <= next_vector;
                     stacked_pc <= (next_src == ELC_SRC_TRAP) ? cpu_pc
                                   : cpu_pc - 16'h0001;
                     push_regs <= 1'b1;
                     mask_bit <= 1'b1;
                     state <= ELC_STACK;
                  end
               end
               ELC_STACK: begin
                  if (cpu.stack_done) begin
                     push_regs <= 1'b0;
                     state <= ELC_RUN;
                  end
               end
               ELC_WAIT: begin
                  if (wake) begin
                     cpu_clock_en <= 1'b1;
                     take_exception <= 1'b1;
                     vector_addr <= next_vector;
                     stacked_pc <= cpu_pc - 16'h0001;
                     push_regs <= 1'b1;
                     mask_bit <= 1'b1;
                     state <= ELC_STACK;
                  end
               end
               ELC_STOP: begin
                  recover_count <= 13'h0000;
                  if (wake) begin
                     osc_clock_en <= 1'b1;
                     state <= ELC_RECOVER;
                  end
               end
               ELC_RECOVER: begin
                  recover_count <= recover_count + 13'h0001;
                  if (recover_count + 13'h0001 >= recover_limit) begin
                     cpu_clock_en <= 1'b1;
                     periph_clock_en <= 1'b1;
                     take_exception <= 1'b1;
                     vector_addr <= next_vector;
                     stacked_pc <= cpu_pc - 16'h0001;
                     push_regs <= 1'b1;
                     mask_bit <= 1'b1;
                     state <= ELC_STACK;
                  end
               end
               default: state <= ELC_RUN;
            endcase
         end
      end
   end

   // break state and flag protection
   always_ff @(posedge mclk) begin
      if (reset) begin
         in_break <= 1'b0;
         flag_clear_allow <= 1'b1;
      end else if (clk_en) begin
         in_break <= break_request;
         flag_clear_allow <= ~break_request | flag_ctrl[BIT_CLEAR_ENABLE];
      end
   end

   // upper index byte never joins the stacked frame
   always_ff @(posedge mclk) begin
      if (reset) begin
         push_index_high <= 1'b0;
      end else if (clk_en) begin
         push_index_high <= 1'b0;
      end
   end

   // pending views, reserved bits zero
   always_comb begin
      status_one = 8'h00;
      status_one[BIT_EXT_PIN] = src_request[0];
      status_one[BIT_CH0] = src_request[1];
      status_one[BIT_CH1] = src_request[2];
      status_one[BIT_OVF] = src_request[3];
      status_two = 8'h00;
      status_two[BIT_KEYBOARD] = src_request[4];
      status_three = 8'h00;
      status_three[BIT_ADC] = src_request[5];
   end

   assign apb_write = psel & penable & pwrite & ~pready;
   assign apb_read = psel & ~penable & ~pwrite;

   // apb slave, one wait state
   always_ff @(posedge mclk) begin
      if (reset) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (clk_en) begin
         pready <= psel & penable & ~pready;
         pslverr <= 1'b0;
         if (apb_read) begin
            prdata <= 32'h0000_0000;
            case (paddr)
               ADDR_STATUS_ONE: prdata <= {24'h00_0000, status_one};
               ADDR_STATUS_TWO: prdata <= {24'h00_0000, status_two};
               ADDR_STATUS_THREE: prdata <= {24'h00_0000, status_three};
               ADDR_BREAK_STATUS: prdata <= {24'h00_0000, break_status};
               ADDR_BREAK_FLAG_CTRL: prdata <= {24'h00_0000, flag_ctrl};
               ADDR_CONFIG_ONE: prdata <= {24'h00_0000, config_one};
               default: prdata <= 32'h0000_0000;
            endcase
         end
         if (psel & penable & ~pready) begin
            pslverr <= ~(paddr inside {ADDR_STATUS_ONE, ADDR_STATUS_TWO, ADDR_STATUS_THREE,
                         ADDR_BREAK_STATUS, ADDR_BREAK_FLAG_CTRL, ADDR_CONFIG_ONE});
         end
      end
   end

   // writable registers; status views ignore writes
   always_ff @(posedge mclk) begin
      if (reset) begin
         break_status <= BREAK_STATUS_RESET;
         flag_ctrl <= FLAG_CTRL_RESET;
         config_one <= CONFIG_ONE_RESET;
      end else if (clk_en) begin
         if (apb_write && paddr == ADDR_BREAK_FLAG_CTRL) begin
            flag_ctrl <= pwdata[7:0];
         end
         if (apb_write && paddr == ADDR_CONFIG_ONE) begin
            config_one <= pwdata[7:0];
         end
         if (apb_write && paddr == ADDR_BREAK_STATUS && !pwdata[BIT_LOWPOWER_FLAG]) begin
            break_status[BIT_LOWPOWER_FLAG] <= 1'b0;
         end
         if (break_request && (state == ELC_WAIT || state == ELC_STOP)) begin
            break_status[BIT_LOWPOWER_FLAG] <= 1'b1;
         end
      end
   end
endmodule // elc_ctrl

/* hdl/elc_pkg.sv */
// package for the exception and low-power controller
// Functional notes
// - latch requests, arbitrate at entry, output vector code; the code does not latch and gates the src_request levels directly
// - latched request holds until serviced or mask clear; the code keeps no latch, so a src_request dropped before service is lost
// - entry stacks registers and sets global mask
// - return from trap unstacks registers
// - hardware requests checked only at instruction end
// - service only if mask clear and enabled
// - highest priority pending request wins
// - pending at return is serviced before next instruction
// - upper index byte is not stacked
// - software trap ignores mask; mask gates others
// - trap stacks pc; hardware stacks pc minus one
// - fixed descending vector addresses per source
// - pending flags read one while source requests
// - status one bits 0,1,3,7 read zero
// - status two bits 0-6 read zero
// - status three bits 1-7 read zero
// - resets share top priority, never arbitrated
// - break forces the software trap vector
// - break protects flags unless clear enable set
// - two-step clears stay protected during break
// - wait and stop clear mask, stop cpu clock
// - wait keeps peripheral clocks; interrupt wakes cpu
// - break in wait sets lowpower flag; exits wait
// - stop gates clocks, holds counter, recovery then stacking
// - recovery 4096 or 32 fast-clock cycles
package elc_pkg;
   localparam logic [11:0] ADDR_STATUS_ONE = 12'h000;
   localparam logic [11:0] ADDR_STATUS_TWO = 12'h004;
   localparam logic [11:0] ADDR_STATUS_THREE = 12'h008;
   localparam logic [11:0] ADDR_BREAK_STATUS = 12'h00c;
   localparam logic [11:0] ADDR_BREAK_FLAG_CTRL = 12'h010;
   localparam logic [11:0] ADDR_CONFIG_ONE = 12'h014;
   localparam int BIT_EXT_PIN = 2;
   localparam int BIT_CH0 = 4;
   localparam int BIT_CH1 = 5;
   localparam int BIT_OVF = 6;
   localparam int BIT_KEYBOARD = 7;
   localparam int BIT_ADC = 0;
   localparam int BIT_LOWPOWER_FLAG = 1;
   localparam int BIT_CLEAR_ENABLE = 7;
   localparam int BIT_SHORT_RECOVERY = 7;
   localparam logic [7:0] BREAK_STATUS_RESET = 8'h00;
   localparam logic [7:0] FLAG_CTRL_RESET = 8'h00;
   localparam logic [7:0] CONFIG_ONE_RESET = 8'h00;
   localparam logic [15:0] VEC_RESET = 16'hfffe;
   localparam logic [15:0] VEC_TRAP = 16'hfffc;
   localparam logic [15:0] VEC_EXT_PIN = 16'hfffa;
   localparam logic [15:0] VEC_CH0 = 16'hfff6;
   localparam logic [15:0] VEC_CH1 = 16'hfff4;
   localparam logic [15:0] VEC_OVF = 16'hfff2;
   localparam logic [15:0] VEC_KEYBOARD = 16'hffe0;
   localparam logic [15:0] VEC_ADC = 16'hffde;
   localparam int NUM_SOURCES = 6;
   localparam logic [12:0] RECOVERY_LONG = 13'h1000;
   localparam logic [12:0] RECOVERY_SHORT = 13'h0020;
   typedef enum logic [2:0] {
      ELC_SRC_NONE, ELC_SRC_EXT, ELC_SRC_CH0, ELC_SRC_CH1, ELC_SRC_OVF, ELC_SRC_KEY,
      ELC_SRC_ADC, ELC_SRC_TRAP
   } elc_source_e;
   typedef enum {ELC_RUN, ELC_STACK, ELC_WAIT, ELC_STOP, ELC_RECOVER} elc_state_e;
   typedef struct packed {
      logic instr_done;
      logic trap_instr;
      logic rti_instr;
      logic wait_instr;
      logic stop_instr;
      logic stack_done;
   } elc_cpu_s;
endpackage

/* test/elc_ctrl_asserts.sv */
// assertion checker for the exception and low-power controller
`timescale 1ns/100ps
module elc_ctrl_asserts
   import elc_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic break_request,
   input wire logic reset_request,
   input wire elc_cpu_s cpu,
   input wire logic [15:0] cpu_pc,
   input wire logic mask_bit,
   input wire logic take_exception,
   input wire logic [15:0] vector_addr,
   input wire logic [15:0] stacked_pc,
   input wire logic push_regs,
   input wire logic pop_regs,
   input wire logic push_index_high,
   input wire logic cpu_clock_en,
   input wire logic periph_clock_en
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_trap;
      cpu.instr_done && cpu.trap_instr && clk_en && !reset_request && !push_regs;
   endsequence
   a_apb_wait: assert property (s_setup |=> !pready ##1 pready)
      else $error("apb answer late or early");
   a_status_zeros: assert property (pready && !pwrite && paddr == ADDR_STATUS_ONE |->
      (prdata & 32'hffff_ff8b) == 32'h0) else $error("status one zero bits set");
   a_entry_masks: assert property (take_exception && vector_addr != VEC_RESET |->
      push_regs ##1 mask_bit)
      else $error("entry without stacking or mask");
   a_push_holds: assert property (push_regs && !cpu.stack_done && !reset_request |=> push_regs)
      else $error("stacking dropped early");
   a_trap_entry: assert property (s_trap |=> take_exception && vector_addr == VEC_TRAP
      && stacked_pc == $past(cpu_pc)) else $error("trap entry wrong");
   a_rti_pops: assert property (cpu.rti_instr && clk_en && !reset_request |=> pop_regs)
      else $error("return did not unstack");
   a_index_kept: assert property (push_index_high == 1'b0)
      else $error("upper index stacked");
   a_mask_blocks: assert property (mask_bit && cpu.instr_done && !cpu.trap_instr
      && !cpu.rti_instr && !break_request && !reset_request && clk_en |=> !take_exception)
      else $error("masked request taken");
   a_wait_entry: assert property (cpu.wait_instr && clk_en && !reset_request |=>
      !cpu_clock_en && periph_clock_en && !mask_bit) else $error("wait entry wrong");
   a_reset_vector: assert property (reset_request && clk_en |->
      ##[1:2] vector_addr == VEC_RESET) else $error("reset vector missing");
endmodule // elc_ctrl_asserts
bind elc_ctrl elc_ctrl_asserts u_elc_ctrl_asserts (.*);

/* test/elc_cpu_model.sv */
// cpu core model: retires commanded instructions and answers stacking
`timescale 1ns/100ps
module elc_cpu_model
   import elc_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic [2:0] op,
   input wire logic slow,
   input wire logic cpu_clock_en,
   input wire logic push_regs,
   output elc_cpu_s cpu,
   output logic [15:0] cpu_pc
);
   logic [3:0] cnt;
   always_ff @(posedge mclk) begin
      cpu <= '0;
      if (reset) begin
         cpu_pc <= 16'h8000;
         cnt <= 4'h0;
      end else begin
         // a gated cpu clock retires nothing
         if (op != 3'h0 && cpu_clock_en) begin
            cpu.instr_done <= 1'b1;
            cpu.trap_instr <= op == 3'h2;
            cpu.rti_instr <= op == 3'h3;
            cpu.wait_instr <= op == 3'h4;
            cpu.stop_instr <= op == 3'h5;
            cpu_pc <= cpu_pc + 16'h0002;
         end
         cnt <= push_regs ? cnt + 4'h1 : 4'h0;
         cpu.stack_done <= push_regs && cnt == (slow ? 4'h5 : 4'h1);
      end
   end
endmodule // elc_cpu_model

/* test/exception_and_lowpower_control_tb.sv */
// testbench for the exception and low-power controller
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
   $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module exception_and_lowpower_control_tb
   import elc_pkg::*;
();
   logic mclk, reset, clk_en, psel, penable, pwrite, pready, pslverr, break_request;
   logic reset_request, mask_bit, take_exception, push_regs, pop_regs, push_index_high;
   logic discard_prefetch, cpu_clock_en, periph_clock_en, osc_clock_en, in_break;
   logic flag_clear_allow, slow, rsp;
   logic [2:0] op;
   logic [5:0] src_request, src_enable;
   logic [11:0] paddr;
   logic [15:0] cpu_pc, vector_addr, stacked_pc;
   logic [31:0] pwdata, prdata, rd, seed;
   logic [31:0] ex [3];
   elc_cpu_s cpu;
   int err_total, tests_run, n, k, ndisc, ev, ep;
   int qv[$], qp[$];
   localparam logic [15:0] VT [6] = '{VEC_EXT_PIN, VEC_CH0, VEC_CH1, VEC_OVF,
      VEC_KEYBOARD, VEC_ADC};
   elc_ctrl u_elc_ctrl (.*);
   elc_cpu_model u_elc_cpu_model (.*);
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // every entry except a reset entry is compared with the queued expectation
   always @(posedge mclk) begin
      if (discard_prefetch === 1'b1) ndisc++;
      if (take_exception === 1'b1 && vector_addr !== VEC_RESET) begin
         ev = qv.size() ? qv.pop_front() : 0;
         ep = qp.size() ? qp.pop_front() : -1;
         `CHK(vector_addr, ev[15:0])
         if (ep >= 0) `CHK(stacked_pc, ep[15:0])
      end
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic report_and_stop(input int to);
      err_total += to;
      $display("checks %0d, wrong %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) report_and_stop(1);
      rd = prdata;
      rsp = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic do_op(input logic [2:0] o);
      op <= o;
      @(posedge mclk);
      op <= 3'h0;
      @(posedge mclk);
   endtask
   task automatic wait_exc(input int lim);
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (take_exception !== 1'b1 && n < lim);
      if (n >= lim) report_and_stop(1);
      repeat (8) if (push_regs === 1'b1) @(posedge mclk);
      `CHK(push_regs, 1'b0)
   endtask
   initial begin
      {reset, clk_en} = 2'b11;
      {psel, penable, pwrite, break_request, reset_request, slow} = '0;
      {paddr, pwdata, src_request, src_enable, op} = '0;
      {err_total, tests_run, ndisc} = '0;
      seed = lfsr(32'h2938_53a2);
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      src_request <= seed[5:0];
      @(posedge mclk);
      ex[0] = {24'h0, 1'b0, seed[3:1], 1'b0, seed[0], 2'b00};
      ex[1] = {24'h0, seed[4], 7'h0};
      ex[2] = {31'h0, seed[5]};
      apb(1'b1, ADDR_STATUS_ONE, 32'hffff_ffff);
      `CHK(rsp, 1'b0)
      for (k = 0; k < 3; k++) begin
         apb(1'b0, 12'(4 * k), 32'h0);
         `CHK(rd, ex[k])
      end
      src_request <= 6'h3f;
      src_enable <= 6'h3f;
      do_op(3'h1);
      @(posedge mclk);
      `CHK(take_exception, 1'b0)
      src_request <= 6'h0;
      $display("status test done");
      qv.push_back(VEC_TRAP);
      qp.push_back(cpu_pc + 16'h0002);
      do_op(3'h2);
      wait_exc(10);
      do_op(3'h3);
      $display("trap test done");
      for (k = 0; k < 6; k++) begin
         slow <= seed[k];
         do_op(3'h4);
         repeat (2) @(posedge mclk);
         `CHK(mask_bit, 1'b0)
         qv.push_back(VT[k]);
         qp.push_back(cpu_pc - 1);
         if (k < 5) qv.push_back(VT[k + 1]);
         if (k < 5) qp.push_back(-1);
         src_request <= 6'h3 << k;
         wait_exc(10);
         src_request[k] <= 1'b0;
         do_op(3'h3);
         if (k < 5) wait_exc(10);
         src_request <= 6'h0;
         do_op(3'h3);
      end
      `CHK(ndisc, 5)
      $display("priority test done");
      do_op(3'h4);
      repeat (2) @(posedge mclk);
      qv.push_back(VEC_TRAP);
      qp.push_back(-1);
      break_request <= 1'b1;
      wait_exc(10);
      `CHK(in_break, 1'b1)
      `CHK(flag_clear_allow, 1'b0)
      apb(1'b0, ADDR_BREAK_STATUS, 32'h0);
      `CHK(rd[BIT_LOWPOWER_FLAG], 1'b1)
      apb(1'b1, ADDR_BREAK_FLAG_CTRL, 32'h0000_0080);
      @(posedge mclk);
      `CHK(flag_clear_allow, 1'b1)
      break_request <= 1'b0;
      do_op(3'h3);
      $display("break test done");
      for (k = 0; k < 2; k++) begin
         apb(1'b1, ADDR_CONFIG_ONE, k ? 32'h0 : 32'h0000_0080);
         do_op(3'h5);
         repeat (3) @(posedge mclk);
         `CHK(osc_clock_en, 1'b0)
         qv.push_back(VEC_EXT_PIN);
         qp.push_back(-1);
         src_request <= 6'h1;
         wait_exc(5000);
         ev = k ? 4096 : 32;
         `CHK(n >= ev && n <= ev + 4, 1'b1)
         src_request <= 6'h0;
         do_op(3'h3);
      end
      $display("stop test done");
      reset_request <= 1'b1;
      @(posedge mclk);
      reset_request <= 1'b0;
      repeat (2) @(posedge mclk);
      `CHK(vector_addr, VEC_RESET)
      $display("reset test done");
      report_and_stop(0);
   end
endmodule // exception_and_lowpower_control_tb
